// File: rtl/async_serial_defines.svh
// constants for the asynchronous serial transceiver
// assumes one clock, synchronous active-low reset
`ifndef ASYNC_SERIAL_DEFINES_SVH
`define ASYNC_SERIAL_DEFINES_SVH
`define OVS_LAST 4'hF
`define OVS_SAMP_A 4'h7
`define OVS_SAMP_B 4'h8
`define OVS_SAMP_C 4'h9
`define FRAME_LEN_8 4'hA
`define FRAME_LEN_9 4'hB
`define DATA_LEN_8 4'h8
`define DATA_LEN_9 4'h9
`define TAIL_LEN 4'h1
`define PRESCALE_1 5'h01
`define PRESCALE_3 5'h03
`define PRESCALE_4 5'h04
`define PRESCALE_13 5'h0D
`define TX_EMPTY_RESET 1'h1
`define TX_DONE_RESET 1'h1
`endif

// File: rtl/async_serial_pkg.sv
// types for the asynchronous serial transceiver
// assumes the defines header is included by the design
package async_serial_pkg;
    typedef enum logic [1:0] {TX_OFF, TX_READY, TX_SEND} tx_state_type;
    typedef enum logic [1:0] {KIND_DATA, KIND_IDLE, KIND_BREAK, KIND_TAIL} kind_type;
    typedef enum logic [2:0] {RX_OFF, RX_HUNT, RX_START, RX_DATA, RX_STOP} rx_state_type;
    typedef struct packed {
        logic [1:0] common_prescale_sel;
        logic [2:0] tx_divider_sel;
        logic [2:0] rx_divider_sel;
        logic [7:0] tx_fine_prescaler;
        logic [7:0] rx_fine_prescaler;
    } baud_cfg_type;
    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic tx_complete_flag;
        logic rx_data_ready_flag;
        logic idle_flag;
        logic overrun_flag;
        logic noise_flag;
        logic framing_error_flag;
    } flags_type;
    typedef struct packed {
        tx_state_type tx_st;
        kind_type tx_kind;
        logic [10:0] tx_shift;
        logic [3:0] tx_left;
        logic [11:0] tx_pre;
        logic [3:0] tx_phase;
        logic [7:0] tx_buf;
        logic tx_buf9;
        logic tx_buf_full;
        logic en_prev;
        logic idle_pending;
        logic break_tail;
        logic armed;
        rx_state_type rx_st;
        logic [11:0] rx_pre;
        logic [3:0] rx_phase;
        logic [1:0] rx_samp;
        logic [8:0] rx_shift;
        logic [3:0] rx_left;
        logic rx_noise;
        logic rx_wait_high;
        logic [3:0] idle_cnt;
        logic idle_armed;
        logic [7:0] rx_buf;
        logic rx_nine;
        flags_type flags;
        logic tx_out;
        logic irq;
    } state_type;
endpackage : async_serial_pkg

// File: rtl/async_serial_transceiver.sv
// full-duplex asynchronous serial transceiver with flag logic
// assumes inputs synchronous to clk; software strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_defines.svh"
module async_serial_transceiver
    import async_serial_pkg::*;
#(
    parameter int PRE_W = 12
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control bits
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic send_break,
    input wire logic word_9bit,
    input wire logic tx_ninth_bit,
    input wire logic tx_empty_irq_enable,
    input wire logic tx_complete_irq_enable,
    input wire logic rx_irq_enable,
    input wire logic idle_irq_enable,
    input wire logic global_irq_mask,
    input wire baud_cfg_type baud_cfg,
    // software access strobes
    input wire logic status_access,
    input wire logic data_write,
    input wire logic [7:0] data_wdata,
    input wire logic data_read,
    // receive data, status flags and interrupt
    output logic [7:0] rx_data,
    output logic rx_ninth_bit,
    output flags_type flags,
    output logic irq,
    // serial pins
    input wire logic serial_rx_pin,
    output logic serial_tx_out,
    output logic serial_tx_oe
);
    // ****************************************
    // baud and frame helpers
    // ****************************************
    function automatic logic [PRE_W-1:0] baud_div(input logic [1:0] psel,
        input logic [2:0] dsel, input logic [7:0] fine);
        logic [4:0] factor;
        logic [PRE_W-1:0] base;
        factor = `PRESCALE_1;
        unique case (psel)
            2'h0: factor = `PRESCALE_1;
            2'h1: factor = `PRESCALE_3;
            2'h2: factor = `PRESCALE_4;
            2'h3: factor = `PRESCALE_13;
        endcase
        base = PRE_W'({factor, 1'b0}) << dsel;
        baud_div = (fine != 8'h00) ? PRE_W'(fine) : base;
    endfunction : baud_div

    function automatic logic [14:0] make_frame(input kind_type k, input logic m,
        input logic [7:0] d, input logic nine);
        logic [3:0] len;
        len = m ? `FRAME_LEN_9 : `FRAME_LEN_8;
        make_frame = {len, 11'h7FF};
        unique case (k)
            KIND_DATA: make_frame = m ? {len, 1'b1, nine, d, 1'b0} : {len, 2'h3, d, 1'b0};
            KIND_IDLE: make_frame = {len, 11'h7FF};
            KIND_BREAK: make_frame = {len, 11'h000};
            KIND_TAIL: make_frame = {`TAIL_LEN, 11'h7FF};
        endcase
    endfunction : make_frame

    state_type st_r;
    state_type st_nxt;
    logic [PRE_W-1:0] tx_div;
    logic [PRE_W-1:0] rx_div;
    logic tx_bit_end;
    logic rx_stick;

    assign tx_div = baud_div(baud_cfg.common_prescale_sel, baud_cfg.tx_divider_sel,
        baud_cfg.tx_fine_prescaler);
    assign rx_div = baud_div(baud_cfg.common_prescale_sel, baud_cfg.rx_divider_sel,
        baud_cfg.rx_fine_prescaler);
    assign tx_bit_end = (st_r.tx_pre == '0) && (st_r.tx_phase == `OVS_LAST);
    assign rx_stick = (st_r.rx_pre == '0);

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [14:0] fr;
        logic nxt_load;
        kind_type nxt_kind;
        logic maj;
        logic nz;
        logic [3:0] flen;
        st_nxt = st_r;
        fr = '0;
        nxt_load = 1'b0;
        nxt_kind = KIND_DATA;
        flen = word_9bit ? `FRAME_LEN_9 : `FRAME_LEN_8;
        maj = (st_r.rx_samp[0] & st_r.rx_samp[1]) | (st_r.rx_samp[0] & serial_rx_pin)
            | (st_r.rx_samp[1] & serial_rx_pin);
        nz = !((st_r.rx_samp == 2'h3 && serial_rx_pin) || (st_r.rx_samp == 2'h0 && !serial_rx_pin));
        // prescalers, 16 sample ticks per bit
        st_nxt.tx_pre = (st_r.tx_pre == '0) ? tx_div - 1'b1 : st_r.tx_pre - 1'b1;
        st_nxt.tx_phase = st_r.tx_phase + 4'((st_r.tx_pre == '0));
        st_nxt.rx_pre = rx_stick ? rx_div - 1'b1 : st_r.rx_pre - 1'b1;
        st_nxt.rx_phase = st_r.rx_phase + 4'(rx_stick);
        st_nxt.en_prev = tx_enable;
        // software clear sequences; sets below win
        if (data_write && st_r.armed)
        begin
            st_nxt.flags.tx_buffer_empty_flag = 1'b0;
            st_nxt.flags.tx_complete_flag = 1'b0;
        end
        if (data_read && st_r.armed)
        begin
            st_nxt.flags.rx_data_ready_flag = 1'b0;
            st_nxt.flags.overrun_flag = 1'b0;
            st_nxt.flags.noise_flag = 1'b0;
            st_nxt.flags.framing_error_flag = 1'b0;
            st_nxt.flags.idle_flag = 1'b0;
        end
        if (data_write || data_read)
            st_nxt.armed = 1'b0;
        if (status_access)
            st_nxt.armed = 1'b1;
        // ---------------- transmitter ----------------
        if (data_write)
        begin
            st_nxt.tx_buf = data_wdata;
            st_nxt.tx_buf9 = tx_ninth_bit;
            st_nxt.tx_buf_full = 1'b1;
        end
        unique case (st_r.tx_st)
            TX_OFF:
            begin
                if (tx_enable)
                begin
                    nxt_load = 1'b1;
                    nxt_kind = KIND_IDLE;
                end
            end
            TX_READY:
            begin
                if (!tx_enable)
                    st_nxt.tx_st = TX_OFF;
                else if (send_break)
                begin
                    nxt_load = 1'b1;
                    nxt_kind = KIND_BREAK;
                    st_nxt.break_tail = 1'b1;
                end
                else if (data_write || st_r.tx_buf_full)
                begin
                    nxt_load = 1'b1;
                    nxt_kind = KIND_DATA;
                end
            end
            TX_SEND:
            begin
                if (tx_enable && !st_r.en_prev)
                begin
                    st_nxt.idle_pending = 1'b1;
                    st_nxt.tx_buf_full = 1'b0;
                end
                if (tx_bit_end)
                begin
                    st_nxt.tx_shift = {1'b1, st_r.tx_shift[10:1]};
                    st_nxt.tx_left = st_r.tx_left - 1'b1;
                    if (st_r.tx_left == `TAIL_LEN)
                    begin
                        st_nxt.flags.tx_complete_flag = 1'b1;
                        st_nxt.tx_st = TX_READY;
                        if (!tx_enable && !st_r.idle_pending)
                            st_nxt.tx_st = TX_OFF;
                        else if (send_break)
                        begin
                            nxt_load = 1'b1;
                            nxt_kind = KIND_BREAK;
                            st_nxt.break_tail = 1'b1;
                        end
                        else if (st_r.break_tail)
                        begin
                            nxt_load = 1'b1;
                            nxt_kind = KIND_TAIL;
                            st_nxt.break_tail = 1'b0;
                        end
                        else if (st_r.idle_pending || (tx_enable && !st_r.en_prev))
                        begin
                            nxt_load = 1'b1;
                            nxt_kind = KIND_IDLE;
                            st_nxt.idle_pending = 1'b0;
                        end
                        else if (st_r.tx_buf_full)
                        begin
                            nxt_load = 1'b1;
                            nxt_kind = KIND_DATA;
                        end
                    end
                end
            end
            default: st_nxt.tx_st = TX_OFF;
        endcase
        if (nxt_load)
        begin
            if (nxt_kind == KIND_DATA)
            begin
                fr = st_r.tx_buf_full ? make_frame(KIND_DATA, word_9bit, st_r.tx_buf, st_r.tx_buf9)
                    : make_frame(KIND_DATA, word_9bit, data_wdata, tx_ninth_bit);
                st_nxt.tx_buf_full = st_r.tx_buf_full && data_write;
                st_nxt.flags.tx_buffer_empty_flag = 1'b1;
            end
            else
                fr = make_frame(nxt_kind, word_9bit, 8'h00, 1'b0);
            st_nxt.tx_shift = fr[10:0];
            st_nxt.tx_left = fr[14:11];
            st_nxt.tx_kind = nxt_kind;
            st_nxt.tx_st = TX_SEND;
            if (st_r.tx_st != TX_SEND)
            begin
                st_nxt.tx_pre = tx_div - 1'b1;
                st_nxt.tx_phase = 4'h0;
            end
        end
        st_nxt.tx_out = (st_nxt.tx_st == TX_SEND) ? st_nxt.tx_shift[0] : 1'b1;
        // ---------------- receiver ----------------
        if (!rx_enable)
        begin
            st_nxt.rx_st = RX_OFF;
            st_nxt.flags.rx_data_ready_flag = 1'b0;
            st_nxt.flags.overrun_flag = 1'b0;
            st_nxt.flags.noise_flag = 1'b0;
            st_nxt.flags.framing_error_flag = 1'b0;
            st_nxt.flags.idle_flag = 1'b0;
        end
        else
        begin
            unique case (st_r.rx_st)
                RX_OFF:
                begin
                    st_nxt.rx_st = RX_HUNT;
                    st_nxt.idle_cnt = 4'h0;
                    st_nxt.rx_wait_high = 1'b1;
                end
                RX_HUNT:
                begin
                    if (rx_stick && serial_rx_pin)
                        st_nxt.rx_wait_high = 1'b0;
                    if (rx_stick && !serial_rx_pin && !st_r.rx_wait_high)
                    begin
                        st_nxt.rx_st = RX_START;
                        st_nxt.rx_phase = 4'h1;
                        st_nxt.rx_noise = 1'b0;
                        st_nxt.idle_cnt = 4'h0;
                    end
                    else if (rx_stick && !serial_rx_pin)
                        st_nxt.idle_cnt = 4'h0;
                    else if (rx_stick && st_r.rx_phase == `OVS_LAST && st_r.idle_cnt != flen)
                    begin
                        st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
                        if (st_r.idle_cnt + 1'b1 == flen && st_r.idle_armed)
                        begin
                            st_nxt.flags.idle_flag = 1'b1;
                            st_nxt.idle_armed = 1'b0;
                        end
                    end
                end
                RX_START, RX_DATA, RX_STOP:
                begin
                    if (rx_stick && st_r.rx_phase == `OVS_SAMP_A)
                        st_nxt.rx_samp[0] = serial_rx_pin;
                    if (rx_stick && st_r.rx_phase == `OVS_SAMP_B)
                        st_nxt.rx_samp[1] = serial_rx_pin;
                    if (rx_stick && st_r.rx_phase == `OVS_SAMP_C)
                    begin
                        st_nxt.rx_noise = st_r.rx_noise | nz;
                        if (st_r.rx_st == RX_START && maj)
                            st_nxt.rx_st = RX_HUNT;
                        if (st_r.rx_st == RX_DATA)
                        begin
                            st_nxt.rx_shift = {maj, st_r.rx_shift[8:1]};
                            st_nxt.rx_left = st_r.rx_left - 1'b1;
                        end
                        if (st_r.rx_st == RX_STOP)
                        begin
                            st_nxt.rx_st = RX_HUNT;
                            st_nxt.rx_wait_high = !maj;
                            st_nxt.idle_cnt = 4'h0;
                            if (st_r.flags.rx_data_ready_flag)
                                st_nxt.flags.overrun_flag = 1'b1;
                            else
                            begin
                                st_nxt.rx_buf = word_9bit ? st_r.rx_shift[7:0]
                                    : st_r.rx_shift[8:1];
                                st_nxt.rx_nine = word_9bit & st_r.rx_shift[8];
                                st_nxt.flags.rx_data_ready_flag = 1'b1;
                                st_nxt.flags.noise_flag = st_r.rx_noise | nz;
                                st_nxt.flags.framing_error_flag = !maj;
                                st_nxt.idle_armed = 1'b1;
                            end
                        end
                    end
                    if (rx_stick && st_r.rx_phase == `OVS_LAST)
                    begin
                        if (st_r.rx_st == RX_START)
                        begin
                            st_nxt.rx_st = RX_DATA;
                            st_nxt.rx_left = word_9bit ? `DATA_LEN_9 : `DATA_LEN_8;
                        end
                        else if (st_r.rx_st == RX_DATA && st_r.rx_left == 4'h0)
                            st_nxt.rx_st = RX_STOP;
                    end
                end
                default: st_nxt.rx_st = RX_OFF;
            endcase
        end
        st_nxt.irq = !global_irq_mask && ((st_nxt.flags.tx_buffer_empty_flag && tx_empty_irq_enable)
            || (st_nxt.flags.tx_complete_flag && tx_complete_irq_enable)
            || ((st_nxt.flags.rx_data_ready_flag || st_nxt.flags.overrun_flag) && rx_irq_enable)
            || (st_nxt.flags.idle_flag && idle_irq_enable));
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.tx_st <= TX_OFF;
            st_r.rx_st <= RX_OFF;
            st_r.flags.tx_buffer_empty_flag <= `TX_EMPTY_RESET;
            st_r.flags.tx_complete_flag <= `TX_DONE_RESET;
            st_r.idle_armed <= 1'b1;
            st_r.tx_out <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign rx_data = st_r.rx_buf;
    assign rx_ninth_bit = st_r.rx_nine;
    assign flags = st_r.flags;
    assign irq = st_r.irq;
    assign serial_tx_out = st_r.tx_out;
    assign serial_tx_oe = tx_enable;

    // ****************************************
    // checks
    // ****************************************
    tx_idle_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.tx_st == TX_READY |-> serial_tx_out) else $error("idle line not high");
    start_bit_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.tx_st == TX_SEND && st_r.tx_kind == KIND_DATA
        && st_r.tx_left == (word_9bit ? `FRAME_LEN_9 : `FRAME_LEN_8)
        |-> !serial_tx_out) else $error("start bit not low");
    stop_bit_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.tx_st == TX_SEND && st_r.tx_kind != KIND_BREAK && st_r.tx_left == `TAIL_LEN
        |-> serial_tx_out)
        else $error("stop bit not high");
    break_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.tx_st == TX_SEND && st_r.tx_kind == KIND_BREAK |-> !serial_tx_out)
        else $error("break frame not low");
    preamble_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.tx_st == TX_OFF && tx_enable |=> st_r.tx_st == TX_SEND && st_r.tx_kind == KIND_IDLE)
        else $error("no idle frame on enable");
    direct_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.tx_st == TX_READY && tx_enable && !send_break && data_write
        |=> st_r.tx_st == TX_SEND && flags.tx_buffer_empty_flag) else $error("direct load failed");
    frame_done_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.tx_st == TX_SEND && tx_bit_end && st_r.tx_left == `TAIL_LEN
        |=> flags.tx_complete_flag) else $error("complete flag not set");
    rx_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(flags.rx_data_ready_flag) |-> $past(data_read && st_r.armed) || $past(!rx_enable))
        else $error("ready flag cleared without sequence");
    overrun_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(flags.overrun_flag) |-> $stable(rx_data)) else $error("overrun lost buffer");
    irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        global_irq_mask |=> !irq) else $error("irq while masked");
    data_frame_c: cover property (@(posedge clk) disable iff (!rst_n)
        st_r.tx_kind == KIND_DATA ##1 flags.tx_complete_flag);
    break_tail_c: cover property (@(posedge clk) disable iff (!rst_n)
        st_r.tx_st == TX_SEND && st_r.tx_kind == KIND_TAIL);
    rx_char_c: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(flags.rx_data_ready_flag));
    overrun_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(flags.overrun_flag));
endmodule : async_serial_transceiver
`default_nettype wire

// File: verification/serial_peer.sv
// far-side serial equipment: frame sender and frame decoder
// assumes an idle-high line and bit times counted in clk cycles
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
    parameter int RX_BIT = 32
)(
    // clock and word length
    input wire logic clk,
    input wire logic nine,
    // serial lines
    input wire logic tx_line,
    input wire logic tx_oe,
    output logic rx_line
);
    // ****************
    // sender / decoder
    // ****************
    int tx_bit = 16;
    logic [8:0] got[$];
    logic stops[$];
    logic [8:0] acc;
    initial rx_line = 1'b1;
    task automatic send(input logic [8:0] w, input logic stop, input logic glitch);
        rx_line = 1'b0;
        repeat (RX_BIT) @(negedge clk);
        for (int i = 0; i < (nine ? 9 : 8); i++)
        begin
            rx_line = w[i];
            repeat (RX_BIT / 2) @(negedge clk);
            rx_line = w[i] ^ (glitch && i == 0);
            repeat (2) @(negedge clk);
            rx_line = w[i];
            repeat (RX_BIT / 2 - 2) @(negedge clk);
        end
        rx_line = stop;
        repeat (RX_BIT) @(negedge clk);
        rx_line = 1'b1;
    endtask : send
    always @(negedge tx_line)
    begin
        if (tx_oe)
        begin
            acc = 9'h000;
            repeat (tx_bit / 2) @(posedge clk);
            for (int i = 0; i < (nine ? 9 : 8); i++)
            begin
                repeat (tx_bit) @(posedge clk);
                acc[i] = tx_line;
            end
            repeat (tx_bit) @(posedge clk);
            stops.push_back(tx_line);
            got.push_back(acc);
        end
    end
endmodule : serial_peer
`default_nettype wire

// File: verification/test_async_serial_transceiver.sv
// self-checking bench for the serial transceiver
// assumes serial_peer as the far side; tx fine divisor 1, rx fine divisor 2
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_transceiver;
    import async_serial_pkg::*;
    // *****************
    // stimulus / checks
    // *****************
    logic clk = 1'b0, rst_n = 1'b0, tx_enable = 1'b0, rx_enable = 1'b0, send_break = 1'b0;
    logic word_9bit = 1'b0, tx_ninth_bit = 1'b0, global_irq_mask = 1'b0;
    logic tx_empty_irq_enable = 1'b0, tx_complete_irq_enable = 1'b0;
    logic rx_irq_enable = 1'b1, idle_irq_enable = 1'b0;
    logic status_access = 1'b0, data_write = 1'b0, data_read = 1'b0;
    logic [7:0] data_wdata = 8'h00;
    baud_cfg_type baud_cfg = '{2'h0, 3'h0, 3'h0, 8'h01, 8'h02};
    logic [7:0] rx_data;
    logic rx_ninth_bit, irq, serial_rx_pin, serial_tx_out, serial_tx_oe;
    flags_type flags;
    int fails = 0, compares = 0, cycles = 0;
    logic [8:0] w, v;
    always #20 clk = ~clk;
    async_serial_transceiver uut (.clk(clk), .rst_n(rst_n), .tx_enable(tx_enable),
        .rx_enable(rx_enable), .send_break(send_break), .word_9bit(word_9bit),
        .tx_ninth_bit(tx_ninth_bit), .tx_empty_irq_enable(tx_empty_irq_enable),
        .tx_complete_irq_enable(tx_complete_irq_enable), .rx_irq_enable(rx_irq_enable),
        .idle_irq_enable(idle_irq_enable), .global_irq_mask(global_irq_mask),
        .baud_cfg(baud_cfg), .status_access(status_access), .data_write(data_write),
        .data_wdata(data_wdata), .data_read(data_read), .rx_data(rx_data),
        .rx_ninth_bit(rx_ninth_bit), .flags(flags), .irq(irq),
        .serial_rx_pin(serial_rx_pin), .serial_tx_out(serial_tx_out),
        .serial_tx_oe(serial_tx_oe));
    serial_peer #(.RX_BIT(32)) peer (.clk(clk), .nine(word_9bit), .tx_line(serial_tx_out),
        .tx_oe(serial_tx_oe), .rx_line(serial_rx_pin));
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk
    function automatic logic [8:0] fit(input logic [8:0] d, input logic nine);
        return nine ? d : {1'b0, d[7:0]};
    endfunction : fit
    // status access, then data write (wr) or read, then settle
    task automatic sw_seq(input logic wr, input logic [8:0] d);
        @(negedge clk) status_access = 1'b1;
        @(negedge clk) status_access = 1'b0;
        data_write = wr;
        data_read = ~wr;
        {tx_ninth_bit, data_wdata} = d;
        @(negedge clk) data_write = 1'b0;
        data_read = 1'b0;
        @(negedge clk);
    endtask : sw_seq
    task automatic tx_word(input int n);
        w = fit($urandom, word_9bit);
        sw_seq(1'b1, w);
        chk("load", 9'({flags.tx_buffer_empty_flag, flags.tx_complete_flag}), 9'h002);
        for (int i = 0; i < 16 * peer.tx_bit && peer.got.size() <= n; i++) @(posedge clk);
        repeat (peer.tx_bit) @(negedge clk);
        chk("word", peer.got[n], w);
        chk("stop", 9'(peer.stops[n]), 9'h001);
        chk("done", 9'(flags.tx_complete_flag), 9'h001);
    endtask : tx_word
    task automatic rx_word(input logic stop, input logic glitch, input logic [8:0] f);
        peer.send(w, stop, glitch);
        repeat (2) @(negedge clk);
        chk("rx flags", 9'(flags[4:0]), f);
    endtask : rx_word
    initial
    begin
        w = $urandom(32'h9F66D981);
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk) chk("reset", {1'b0, serial_tx_out, flags}, 9'h0E0);
        tx_enable = 1'b1;
        repeat (12 * 16) @(negedge clk);
        chk("preamble", {serial_tx_oe, 8'(peer.got.size())}, 9'h100);
        for (int k = 0; k < 6; k++)
        begin
            word_9bit = $urandom;
            tx_word(k);
        end
        word_9bit = 1'b0;
        sw_seq(1'b1, 9'h0A5);
        sw_seq(1'b1, 9'h03C);
        chk("held", 9'(flags.tx_buffer_empty_flag), 9'h000);
        tx_enable = 1'b0;
        @(negedge clk) tx_enable = 1'b1;
        repeat (40 * 16) @(negedge clk);
        chk("toggle", peer.got[6], 9'h0A5);
        chk("toggle count", 9'(peer.got.size()), 9'h007);
        send_break = 1'b1;
        repeat (14 * 16) @(negedge clk);
        send_break = 1'b0;
        repeat (30 * 16) @(negedge clk);
        chk("break", peer.got[7], 9'h000);
        chk("break end", {7'h00, peer.stops[7], serial_tx_out}, 9'h001);
        chk("break count", 9'(peer.got.size()), 9'h008);
        tx_enable = 1'b0;
        repeat (20 * 16) @(negedge clk);
        baud_cfg = '{2'h1, 3'h1, 3'h0, 8'h00, 8'h02};
        peer.tx_bit = 32 * 3 * 2;
        tx_enable = 1'b1;
        repeat (11 * 192) @(negedge clk);
        tx_word(8);
        tx_complete_irq_enable = 1'b1;
        @(negedge clk) chk("done irq", 9'(irq), 9'h001);
        tx_complete_irq_enable = 1'b0;
        tx_empty_irq_enable = 1'b1;
        @(negedge clk) chk("empty irq", 9'(irq), 9'h001);
        tx_empty_irq_enable = 1'b0;
        rx_enable = 1'b1;
        repeat (64) @(negedge clk);
        for (int k = 0; k < 4; k++)
        begin
            word_9bit = $urandom;
            w = fit($urandom, word_9bit);
            rx_word(1'b1, k == 3, 9'({3'h4, k == 3, 1'b0}));
            chk("rx word", {rx_ninth_bit, rx_data}, w);
            chk("rx irq", 9'(irq), 9'h001);
            sw_seq(1'b0, 9'h000);
            chk("rx clear", 9'(flags[4:0]), 9'h000);
        end
        word_9bit = 1'b0;
        v = w;
        w = fit($urandom, 1'b0);
        rx_word(1'b1, 1'b0, 9'h010);
        v = w;
        w = fit($urandom, 1'b0);
        rx_word(1'b1, 1'b0, 9'h014);
        chk("rx keep", {rx_ninth_bit, rx_data}, v);
        sw_seq(1'b0, 9'h000);
        rx_word(1'b0, 1'b0, 9'h011);
        chk("rx framed", {rx_ninth_bit, rx_data}, w);
        sw_seq(1'b0, 9'h000);
        idle_irq_enable = 1'b1;
        repeat (12 * 32) @(negedge clk);
        chk("idle", {flags.idle_flag, 7'h00, irq}, 9'h101);
        global_irq_mask = 1'b1;
        repeat (2) @(negedge clk) chk("masked", 9'(irq), 9'h000);
        print_verdict();
    end
endmodule : test_async_serial_transceiver
`default_nettype wire
